// [include/ibsp_pkg.sv]
// constants and types for the guest-bus inbound slave port
package ibsp_pkg;
    // guest transaction type codes
    localparam logic [3:0] TY_READ1 = 4'h0;
    localparam logic [3:0] TY_READ8 = 4'h3;
    localparam logic [3:0] TY_WRITE1 = 4'h4;
    localparam logic [3:0] TY_WRITE8 = 4'h7;
    localparam logic [3:0] TY_CLEAR = 4'hA;
    localparam logic [3:0] TY_RDRET = 4'hC;
    localparam logic [3:0] TY_ERRX = 4'hD;
    // register map
    localparam logic [31:0] REG_STATUS_IDX = 32'h0;
    localparam logic [31:0] REG_ITS_IDX = 32'h1;
    localparam logic [31:0] REG_STATUS_ADDR = REG_STATUS_IDX * 32'h4;
    localparam logic [31:0] REG_ITS_ADDR = REG_ITS_IDX * 32'h4;
    localparam int ST_PORT_HE = 0;
    localparam int ST_PORT_SE = 1;
    localparam int ST_CPU_HE = 2;
    localparam int ST_CPU_FE = 3;
    localparam int ST_DRR_BUSY = 4;
    localparam logic [31:0] ITS_RST = 32'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // counts in guest-bus cycles, except QUIET_CYC in ref_clk_i cycles; IRQ_SYNC_RST is a reset value
    localparam int DRR_NOTIFY_CYC = 2;
    localparam int DRR_STD_CYC = 8;
    localparam logic [7:0] ALIGN_ERR_GCYC = 8'h40;
    localparam logic [2:0] QUIET_CYC = 3'h7;
    localparam logic [2:0] IRQ_SYNC_RST = 3'h7;

    typedef struct packed {
        logic addr_valid;
        logic [3:0] ty;
        logic [31:0] addr;
        logic [31:0] data;
        logic connected;
        logic prefetch;
        logic par_ok;
        logic err_n;
    } ibsp_gin_t;

    typedef enum logic [2:0] {K_READ, K_WRITE, K_RDRET, K_CLEAR, K_IRQ, K_DERR, K_RFAIL} ibsp_kind_t;

    typedef struct packed {
        ibsp_kind_t kind;
        logic [3:0] words;
        logic rmw;
        logic connected;
        logic prefetch;
        logic [31:0] addr;
        logic [31:0] data;
        logic [7:0] tag;
    } ibsp_entry_t;

    typedef enum logic [2:0] {S_IDLE, S_QUEUE, S_ACK, S_ERR, S_DELAY} ibsp_fsm_t;
    typedef enum logic [1:0] {D_IDLE, D_NOTIFY, D_ERROR, D_STD} ibsp_drr_t;
endpackage

// [design/ibsp_top.sv]
// guest-bus inbound slave port with error handling and register slave
`timescale 1ns/1ps
`default_nettype none
// Contract
// - four guest kinds and three events become entries
// - reads supply 1/2/4/8 full words, unshifted
// - guest writes posted, no completion sent
// - writes of two words or less use RMW
// - write entries omit connected and prefetch
// - read returns matched to outstanding read tag
// - clear returns four words, zeroes addressed word
// - error type logs hard error, write handshake
// - irq negation enqueues entry to target register
// - direct-io read failure: soft error, error entry
// - other bus errors set port hard error
// - port hard error turns external direct-io reads into route-failure
// - no mastering or grants under hard or fatal error, except grant during errored return
// - internal accesses refused under processor error
// - external accesses refused under port hard or processor error
// - guest reads errored, writes acked and dropped
// - status hidden only under processor error
// - misaligned write logs error, late error line
// - errored return: notify, error, eight standard
// - read address error reported by errored return
module ibsp_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic gclk_i,
    input wire ibsp_pkg::ibsp_gin_t gin_i,
    input wire logic guest_irq_n_i,
    output logic transfer_ack_n_o,
    output logic transfer_ack_oe_o,
    output logic bus_error_n_o,
    output logic bus_error_oe_o,
    output logic dma_return_req_n_o,
    output logic dma_return_req_oe_o,
    output logic bus_grant_n_o,
    input wire logic guest_bus_req_i,
    input wire logic arb_grant_i,
    output logic master_en_o,
    input wire logic cpu_hard_err_i,
    input wire logic cpu_fatal_err_i,
    input wire logic dio_rd_pend_i,
    input wire logic [7:0] dio_rd_tag_i,
    input wire logic dio_req_valid_i,
    output logic dio_req_ready_o,
    input wire logic dio_req_read_i,
    input wire logic dio_req_internal_i,
    input wire logic [7:0] dio_req_tag_i,
    output logic dio_pass_o,
    input wire logic dio_fail_i,
    input wire logic [7:0] dio_fail_tag_i,
    input wire logic dma_err_ret_i,
    output logic inq_valid_o,
    input wire logic inq_ready_i,
    output var ibsp_pkg::ibsp_entry_t inq_entry_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic [2:0] gclk_s;
        logic gclk_lvl;
        logic [2:0] irq_s;
        logic irq_lvl;
        ibsp_pkg::ibsp_gin_t [2:0] gin_s;
        ibsp_pkg::ibsp_fsm_t st;
        ibsp_pkg::ibsp_drr_t drr;
        logic [7:0] dly;
        logic [3:0] drr_cnt;
        logic [2:0] quiet;
        logic ack_drv, err_drv, port_he, port_se, irq_pend, rfail_pend, derr_pend;
        logic dma_err_pend, pass, inq_v, aw_have, w_have, bvalid, rvalid;
        logic [7:0] rfail_tag, derr_tag;
        logic [31:0] its, aw_addr, wdata, rdata;
        logic [3:0] wstrb;
        logic [1:0] bresp, rresp;
        ibsp_pkg::ibsp_entry_t hold, inbound_queue;
    } ibsp_st_t;

    ibsp_st_t q, n;
    ibsp_pkg::ibsp_gin_t g;
    logic gedge, irq_rise, blocked, cpu_err, slot, drr_on, dio_take, refuse;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] ty_words(input logic [3:0] ty);
        ty_words = 4'(5'h1 << ty[1:0]);
    endfunction

    function automatic logic is_rd(input logic [3:0] ty);
        is_rd = (ty[3:2] == 2'h0) || (ty == ibsp_pkg::TY_CLEAR);
    endfunction

    function automatic logic legal_ty(input logic [3:0] ty);
        legal_ty = !ty[3] || ty == ibsp_pkg::TY_CLEAR || ty == ibsp_pkg::TY_RDRET;
    endfunction

    function automatic logic align_bad(input logic [3:0] ty, input logic [31:0] a);
        logic [3:0] w;
        w = ty_words(ty);
        align_bad = (w == 4'h2 && a[0]) || (w == 4'h4 && a[1:0] != 2'h0)
            || (w == 4'h8 && a[2:0] != 3'h0);
    endfunction

    // ----------------------------------------------------------------
    // edges and conditions
    // ----------------------------------------------------------------
    assign g = q.gin_s[2];
    assign gedge = q.gclk_s[2] && (q.gclk_s[1] == q.gclk_s[2]) && !q.gclk_lvl;
    assign irq_rise = q.irq_s[2] && (q.irq_s[1] == q.irq_s[2]) && !q.irq_lvl;
    assign cpu_err = cpu_hard_err_i || cpu_fatal_err_i;
    assign blocked = q.port_he || cpu_err;
    assign slot = !q.inq_v || inq_ready_i;
    assign drr_on = q.drr != ibsp_pkg::D_IDLE;
    assign dio_take = dio_req_valid_i && !q.rfail_pend;
    assign refuse = dio_req_internal_i ? cpu_err : blocked;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n = q;
        n.gclk_s = {q.gclk_s[1:0], gclk_i};
        n.irq_s = {q.irq_s[1:0], guest_irq_n_i};
        n.gin_s = {q.gin_s[1:0], gin_i};
        if (q.gclk_s[1] == q.gclk_s[2])
            n.gclk_lvl = q.gclk_s[2];
        if (q.irq_s[1] == q.irq_s[2])
            n.irq_lvl = q.irq_s[2];
        n.pass = 1'b0;
        if (inq_ready_i)
            n.inq_v = 1'b0;
        if (q.err_drv || drr_on)
            n.quiet = ibsp_pkg::QUIET_CYC;
        else if (q.quiet != 3'h0)
            n.quiet = q.quiet - 3'h1;

        // register writes
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (q.aw_have && q.w_have)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = ibsp_pkg::RESP_OKAY;
            if (q.aw_addr == ibsp_pkg::REG_ITS_ADDR)
            begin
                for (int i = 0; i < 4; i++)
                    if (q.wstrb[i])
                        n.its[i*8 +: 8] = q.wdata[i*8 +: 8];
            end
            else if (q.aw_addr == ibsp_pkg::REG_STATUS_ADDR)
            begin
                if (cpu_err)
                    n.bresp = ibsp_pkg::RESP_SLVERR;
                else if (q.wstrb[0])
                begin
                    n.port_he = q.port_he && !q.wdata[ibsp_pkg::ST_PORT_HE];
                    n.port_se = q.port_se && !q.wdata[ibsp_pkg::ST_PORT_SE];
                end
            end
            else
                n.bresp = ibsp_pkg::RESP_DECERR;
        end
        if (q.bvalid && s_axi_bready)
            n.bvalid = 1'b0;

        // register reads
        if (q.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rvalid = 1'b1;
            n.rdata = 32'h0;
            n.rresp = ibsp_pkg::RESP_OKAY;
            if (s_axi_araddr == ibsp_pkg::REG_ITS_ADDR)
                n.rdata = q.its;
            else if (s_axi_araddr == ibsp_pkg::REG_STATUS_ADDR && cpu_err)
                n.rresp = ibsp_pkg::RESP_SLVERR;
            else if (s_axi_araddr == ibsp_pkg::REG_STATUS_ADDR)
            begin
                n.rdata[ibsp_pkg::ST_PORT_HE] = q.port_he;
                n.rdata[ibsp_pkg::ST_PORT_SE] = q.port_se;
                n.rdata[ibsp_pkg::ST_CPU_HE] = cpu_hard_err_i;
                n.rdata[ibsp_pkg::ST_CPU_FE] = cpu_fatal_err_i;
                n.rdata[ibsp_pkg::ST_DRR_BUSY] = drr_on;
            end
            else
                n.rresp = ibsp_pkg::RESP_DECERR;
        end

        // events after clears, so a set wins
        if (irq_rise)
            n.irq_pend = 1'b1;
        if (dio_fail_i)
        begin
            n.port_se = 1'b1;
            n.derr_pend = 1'b1;
            n.derr_tag = dio_fail_tag_i;
        end
        if (dma_err_ret_i)
            n.dma_err_pend = 1'b1;
        if (!g.err_n && q.quiet == 3'h0)
            n.port_he = 1'b1;
        if (dio_take && refuse && dio_req_read_i)
        begin
            n.rfail_pend = 1'b1;
            n.rfail_tag = dio_req_tag_i;
        end
        else if (dio_take && !refuse)
            n.pass = 1'b1;

        // guest transactions, one bus cycle per edge
        unique case (q.st)
            ibsp_pkg::S_IDLE:
                if (gedge && g.addr_valid)
                begin
                    n.hold = '0;
                    n.hold.addr = g.addr;
                    n.hold.data = g.data;
                    n.hold.words = ty_words(g.ty);
                    if (g.ty == ibsp_pkg::TY_ERRX)
                    begin
                        n.port_he = 1'b1;
                        n.st = ibsp_pkg::S_ACK;
                    end
                    else if (blocked)
                        n.st = is_rd(g.ty) ? ibsp_pkg::S_ERR : ibsp_pkg::S_ACK;
                    else if (!legal_ty(g.ty) || (g.ty == ibsp_pkg::TY_RDRET && !dio_rd_pend_i))
                    begin
                        n.port_he = 1'b1;
                        n.st = ibsp_pkg::S_ACK;
                    end
                    else if (!g.par_ok || align_bad(g.ty, g.addr))
                    begin
                        n.port_he = 1'b1;
                        if (is_rd(g.ty))
                        begin
                            n.dma_err_pend = 1'b1;
                            n.st = ibsp_pkg::S_ACK;
                        end
                        else
                        begin
                            n.dly = ibsp_pkg::ALIGN_ERR_GCYC;
                            n.st = ibsp_pkg::S_DELAY;
                        end
                    end
                    else
                    begin
                        n.st = ibsp_pkg::S_QUEUE;
                        if (g.ty == ibsp_pkg::TY_RDRET)
                        begin
                            n.hold.kind = ibsp_pkg::K_RDRET;
                            n.hold.tag = dio_rd_tag_i;
                        end
                        else if (g.ty == ibsp_pkg::TY_CLEAR)
                        begin
                            n.hold.kind = ibsp_pkg::K_CLEAR;
                            n.hold.rmw = 1'b1;
                        end
                        else if (g.ty[2])
                        begin
                            n.hold.kind = ibsp_pkg::K_WRITE;
                            n.hold.rmw = n.hold.words <= 4'h2;
                        end
                        else
                        begin
                            n.hold.kind = ibsp_pkg::K_READ;
                            n.hold.connected = g.connected;
                            n.hold.prefetch = g.prefetch;
                        end
                    end
                    n.ack_drv = n.st == ibsp_pkg::S_ACK;
                    n.err_drv = n.st == ibsp_pkg::S_ERR;
                end
            ibsp_pkg::S_QUEUE:
                if (slot)
                begin
                    n.inbound_queue = q.hold;
                    n.inq_v = 1'b1;
                    n.st = ibsp_pkg::S_ACK;
                    n.ack_drv = 1'b1;
                end
            ibsp_pkg::S_DELAY:
                if (gedge && q.dly == 8'h0)
                begin
                    n.st = ibsp_pkg::S_ERR;
                    n.err_drv = 1'b1;
                end
                else if (gedge)
                    n.dly = q.dly - 8'h1;
            ibsp_pkg::S_ACK,
            ibsp_pkg::S_ERR:
                if (gedge)
                begin
                    n.st = ibsp_pkg::S_IDLE;
                    n.ack_drv = 1'b0;
                    n.err_drv = 1'b0;
                end
        endcase

        // other entry sources
        if (slot && q.st != ibsp_pkg::S_QUEUE)
        begin
            n.inbound_queue = '0;
            n.inbound_queue.words = 4'h1;
            if (q.rfail_pend)
            begin
                n.inbound_queue.kind = ibsp_pkg::K_RFAIL;
                n.inbound_queue.tag = q.rfail_tag;
                n.rfail_pend = 1'b0;
                n.inq_v = 1'b1;
            end
            else if (q.derr_pend)
            begin
                n.inbound_queue.kind = ibsp_pkg::K_DERR;
                n.inbound_queue.tag = q.derr_tag;
                n.derr_pend = dio_fail_i;
                n.inq_v = 1'b1;
            end
            else if (q.irq_pend)
            begin
                n.inbound_queue.kind = ibsp_pkg::K_IRQ;
                n.inbound_queue.addr = q.its;
                n.irq_pend = irq_rise;
                n.inq_v = 1'b1;
            end
        end

        // errored read return sequence
        unique case (q.drr)
            ibsp_pkg::D_IDLE:
                if (gedge && q.dma_err_pend && q.st == ibsp_pkg::S_IDLE)
                begin
                    n.drr = ibsp_pkg::D_NOTIFY;
                    n.drr_cnt = 4'(ibsp_pkg::DRR_NOTIFY_CYC - 1);
                    n.dma_err_pend = dma_err_ret_i;
                end
            ibsp_pkg::D_NOTIFY:
                if (gedge && q.drr_cnt == 4'h0)
                    n.drr = ibsp_pkg::D_ERROR;
                else if (gedge)
                    n.drr_cnt = q.drr_cnt - 4'h1;
            ibsp_pkg::D_ERROR:
                if (gedge)
                begin
                    n.drr = ibsp_pkg::D_STD;
                    n.drr_cnt = 4'(ibsp_pkg::DRR_STD_CYC - 1);
                end
            ibsp_pkg::D_STD:
                if (gedge && q.drr_cnt == 4'h0)
                    n.drr = ibsp_pkg::D_IDLE;
                else if (gedge)
                    n.drr_cnt = q.drr_cnt - 4'h1;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            q.irq_s <= ibsp_pkg::IRQ_SYNC_RST;
            q.irq_lvl <= 1'b1;
            q.quiet <= ibsp_pkg::QUIET_CYC;
            q.its <= ibsp_pkg::ITS_RST;
        end
        else if (ce_i)
            q <= n;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign transfer_ack_n_o = 1'b0;
    assign transfer_ack_oe_o = q.ack_drv;
    assign bus_error_n_o = 1'b0;
    assign bus_error_oe_o = q.err_drv || q.drr == ibsp_pkg::D_ERROR;
    assign dma_return_req_n_o = 1'b0;
    assign dma_return_req_oe_o = drr_on;
    assign bus_grant_n_o = !(drr_on || (guest_bus_req_i && arb_grant_i && !blocked));
    assign master_en_o = !blocked;
    assign dio_req_ready_o = !q.rfail_pend;
    assign dio_pass_o = q.pass;
    assign inq_valid_o = q.inq_v;
    assign inq_entry_o = q.inbound_queue;
    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready = !q.w_have && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i || !ce_i);

    AST_GRANT_BLOCK: assert property (blocked && !drr_on |-> bus_grant_n_o && !master_en_o)
        else $error("grant under error");
    AST_IRQ_PEND: assert property (irq_rise |=> q.irq_pend || q.inq_v)
        else $error("irq edge lost");
    AST_IRQ_ONCE: assert property (irq_rise |=> !irq_rise)
        else $error("irq edge seen twice");
    AST_RMW: assert property (q.inq_v && q.inbound_queue.kind == ibsp_pkg::K_WRITE
        |-> q.inbound_queue.rmw == (q.inbound_queue.words <= 4'h2))
        else $error("write rmw flag wrong");
    AST_WR_FIELDS: assert property (q.inq_v && q.inbound_queue.kind == ibsp_pkg::K_WRITE
        |-> !q.inbound_queue.connected && !q.inbound_queue.prefetch)
        else $error("write entry has read fields");
    AST_CLEAR4: assert property (q.inq_v && q.inbound_queue.kind == ibsp_pkg::K_CLEAR
        |-> q.inbound_queue.words == 4'h4 && q.inbound_queue.rmw)
        else $error("clear entry not four words");
    AST_ERRX: assert property (q.st == ibsp_pkg::S_IDLE && gedge && g.addr_valid
        && g.ty == ibsp_pkg::TY_ERRX |=> q.port_he && q.st == ibsp_pkg::S_ACK)
        else $error("error type not handled");
    AST_RD_BLOCK: assert property (q.st == ibsp_pkg::S_IDLE && gedge && g.addr_valid
        && blocked && is_rd(g.ty) |=> q.st == ibsp_pkg::S_ERR ##1 bus_error_oe_o)
        else $error("blocked read not errored");
    AST_RFAIL: assert property (dio_take && dio_req_read_i && !dio_req_internal_i
        && q.port_he |=> q.rfail_pend && !q.pass)
        else $error("route failure missing");
    AST_SOFT: assert property (dio_fail_i |=> q.port_se && (q.derr_pend || q.inq_v))
        else $error("soft error not logged");
    AST_DRR_ERR: assert property (q.drr == ibsp_pkg::D_ERROR
        |-> bus_error_oe_o && dma_return_req_oe_o && !bus_grant_n_o)
        else $error("error cycle lines wrong");
    AST_DRR_STD: assert property (q.drr == ibsp_pkg::D_ERROR && gedge
        |=> q.drr == ibsp_pkg::D_STD && q.drr_cnt == 4'(ibsp_pkg::DRR_STD_CYC - 1))
        else $error("standard cycles count wrong");
    AST_STATUS_HIDE: assert property (s_axi_arvalid && s_axi_arready && cpu_err
        && s_axi_araddr == ibsp_pkg::REG_STATUS_ADDR |=> s_axi_rresp == ibsp_pkg::RESP_SLVERR)
        else $error("status readable under cpu error");

    COV_IRQ: cover property (q.inq_v && inq_ready_i && q.inbound_queue.kind == ibsp_pkg::K_IRQ);
    COV_DRR: cover property (q.drr == ibsp_pkg::D_ERROR);
    COV_RFAIL: cover property (q.inq_v && q.inbound_queue.kind == ibsp_pkg::K_RFAIL);
    COV_WRITE: cover property (q.inq_v && q.inbound_queue.kind == ibsp_pkg::K_WRITE && q.inbound_queue.rmw);
endmodule // ibsp_top
`default_nettype wire

// [testbench/ibsp_guest.sv]
// guest device model on the shared io bus
`timescale 1ns/1ps
`default_nettype none
module ibsp_guest (
    output logic gclk_o,
    output var ibsp_pkg::ibsp_gin_t gin_o,
    output logic irq_n_o
);
    initial
    begin
        gclk_o = 1'b0;
        irq_n_o = 1'b1;
        gin_o = {1'b0, 4'h0, 64'h0, 4'h3};
        forever #80 gclk_o = ~gclk_o;
    end
    // one address cycle, address driven as given
    task automatic xfer(input logic [3:0] ty, input logic [31:0] a, input logic [31:0] d);
        @(negedge gclk_o);
        gin_o.addr_valid <= 1'b1;
        gin_o.ty <= ty;
        gin_o.addr <= a;
        gin_o.data <= d;
        @(negedge gclk_o);
        gin_o.addr_valid <= 1'b0;
        gin_o.data <= ~d;
    endtask
    task automatic irq_pulse;
        @(negedge gclk_o);
        irq_n_o <= 1'b0;
        repeat (3) @(negedge gclk_o);
        irq_n_o <= 1'b1;
    endtask
    task automatic parity_flag;
        repeat (2) @(negedge gclk_o);
        gin_o.err_n <= 1'b0;
        @(negedge gclk_o);
        gin_o.err_n <= 1'b1;
    endtask
endmodule // ibsp_guest
`default_nettype wire

// [testbench/ibsp_top_bench.sv]
// self-checking bench for the guest-bus inbound slave port
`timescale 1ns/1ps
`default_nettype none
module ibsp_top_bench;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, cpu_hard_err_i = 1'b0;
    logic guest_bus_req_i = 1'b1, arb_grant_i = 1'b1, cpu_fatal_err_i = 1'b0, dio_rd_pend_i = 1'b1;
    logic dio_req_valid_i = 1'b0, dio_req_read_i = 1'b0, dio_req_internal_i = 1'b0;
    logic dio_fail_i = 1'b0, dma_err_ret_i = 1'b0, inq_ready_i = 1'b1;
    logic [7:0] dio_rd_tag_i = 8'h0, dio_req_tag_i = 8'h0, dio_fail_tag_i = 8'h0;
    logic gclk_i, guest_irq_n_i, transfer_ack_n_o, transfer_ack_oe_o, bus_error_n_o;
    logic bus_error_oe_o, dma_return_req_n_o, dma_return_req_oe_o, bus_grant_n_o, master_en_o;
    logic dio_req_ready_o, dio_pass_o, inq_valid_o, saw_err = 1'b0, saw_ack = 1'b0;
    ibsp_pkg::ibsp_gin_t gin_i;
    ibsp_pkg::ibsp_entry_t inq_entry_o;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] e, s, exp_q[$];
    logic [31:0] rnd;
    int err_count = 0, checks = 0, seed = 32'hEA5CB290;
    ibsp_top ibsp_top_inst (.*);
    ibsp_guest ibsp_guest_inst (.gclk_o(gclk_i), .gin_o(gin_i), .irq_n_o(guest_irq_n_i));
    initial
    begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic hang(input int n);
        if (n >= 400)
        begin
            chk("wait", 0, 1);
            conclude();
        end
    endtask
    always @(posedge ref_clk_i)
    begin
        if (bus_error_oe_o === 1'b1)
            saw_err <= 1'b1;
        if (transfer_ack_oe_o === 1'b1)
            saw_ack <= 1'b1;
        if (inq_valid_o === 1'b1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : 8'hFF;
            s = {inq_entry_o.kind, inq_entry_o.words, inq_entry_o.rmw};
            if (s[7:5] != ibsp_pkg::K_WRITE)
                s[0] = e[0];
            if (s[7:5] > ibsp_pkg::K_CLEAR)
                s[4:1] = e[4:1];
            chk("inq entry", s, e);
        end
    end
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 400)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        hang(n);
        repeat (40) @(posedge ref_clk_i);
        $display("step done, %0d checks", checks);
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 400);
        s_axi_bready <= 1'b0;
        hang(n);
        chk("bresp", s_axi_bresp, ibsp_pkg::RESP_OKAY);
    endtask
    task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 400);
        s_axi_rready <= 1'b0;
        hang(n);
        chk("rresp", s_axi_rresp, er);
        if (er == ibsp_pkg::RESP_OKAY)
            chk("rdata", s_axi_rdata, ed);
    endtask
    task automatic gx(input logic [3:0] ty, input logic [31:0] a, input logic [7:0] x);
        if (x != 8'h0)
            exp_q.push_back(x);
        ibsp_guest_inst.xfer(ty, a, rnd);
        drain();
    endtask
    initial
    begin
        #1500000;
        chk("run time", 0, 1);
        conclude();
    end
    initial
    begin
        rnd = $random(seed);
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        axr(ibsp_pkg::REG_ITS_ADDR, ibsp_pkg::ITS_RST, ibsp_pkg::RESP_OKAY);
        axw(ibsp_pkg::REG_ITS_ADDR, rnd);
        axr(ibsp_pkg::REG_ITS_ADDR, rnd, ibsp_pkg::RESP_OKAY);
        axr(32'h40, 32'h0, ibsp_pkg::RESP_DECERR);
        chk("grant", bus_grant_n_o, 0);
        cpu_hard_err_i <= 1'b1;
        @(posedge ref_clk_i);
        axr(ibsp_pkg::REG_STATUS_ADDR, 32'h0, ibsp_pkg::RESP_SLVERR);
        chk("master", master_en_o, 0);
        cpu_hard_err_i <= 1'b0;
        gx(ibsp_pkg::TY_WRITE1 + 4'h1, {rnd[31:1], 1'b0}, {ibsp_pkg::K_WRITE, 5'h5});
        chk("ack", saw_ack, 1);
        gx(ibsp_pkg::TY_READ8, {rnd[31:3], 3'h0}, {ibsp_pkg::K_READ, 5'h10});
        gx(ibsp_pkg::TY_CLEAR, {rnd[31:2], 2'h0}, {ibsp_pkg::K_CLEAR, 5'h8});
        gx(ibsp_pkg::TY_RDRET, rnd, {ibsp_pkg::K_RDRET, 5'h2});
        exp_q.push_back({ibsp_pkg::K_IRQ, 5'h0});
        ibsp_guest_inst.irq_pulse();
        drain();
        ibsp_guest_inst.parity_flag();
        drain();
        axr(ibsp_pkg::REG_STATUS_ADDR, 32'h1, ibsp_pkg::RESP_OKAY);
        gx(ibsp_pkg::TY_ERRX, rnd, 8'h0);
        axr(ibsp_pkg::REG_STATUS_ADDR, 32'h1, ibsp_pkg::RESP_OKAY);
        gx(ibsp_pkg::TY_READ1, rnd, 8'h0);
        chk("error line", saw_err, 1);
        chk("grant", bus_grant_n_o, 1);
        dio_req_valid_i <= 1'b1;
        dio_req_read_i <= 1'b1;
        exp_q.push_back({ibsp_pkg::K_RFAIL, 5'h0});
        @(posedge ref_clk_i);
        dio_req_valid_i <= 1'b0;
        drain();
        axw(ibsp_pkg::REG_STATUS_ADDR, 32'h1);
        axr(ibsp_pkg::REG_STATUS_ADDR, 32'h0, ibsp_pkg::RESP_OKAY);
        {dio_fail_i, dma_err_ret_i, dio_req_valid_i} <= 3'h7;
        exp_q.push_back({ibsp_pkg::K_DERR, 5'h0});
        @(posedge ref_clk_i);
        {dio_fail_i, dma_err_ret_i, dio_req_valid_i} <= 3'h0;
        @(posedge ref_clk_i);
        chk("pass", dio_pass_o, 1);
        repeat (20) @(posedge ref_clk_i);
        axr(ibsp_pkg::REG_STATUS_ADDR, 32'h12, ibsp_pkg::RESP_OKAY);
        chk("return req", dma_return_req_oe_o, 1);
        drain();
        conclude();
    end
endmodule // ibsp_top_bench
`default_nettype wire
